// [design/lx_link_exchange.sv]
// Purpose: Exchange-level controller for one end of a data-strobe link.
// Assumes: A decoder on clk_sys_i delivers characters; d_i and s_i are
//          the raw line pins and are synchronised here.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
`include "lx_link_regs.svh"

module lx_link_exchange #(
	parameter int TX_CREDIT_MAX = 56, // Largest transmit credit held.
	parameter int RX_CREDIT_MAX = 56 // Largest credit granted to the peer.
) (
	input wire logic clk_sys_i, // System clock, 10 MHz.
	input wire logic reset_i, // Synchronous reset, active high.
	input wire logic psel_i, // APB select.
	input wire logic penable_i, // APB enable.
	input wire logic pwrite_i, // APB write direction.
	input wire logic [7:0] paddr_i, // APB byte address.
	input wire logic [31:0] pwdata_i, // APB write data.
	output logic [31:0] prdata_o, // APB read data.
	output logic pready_o, // APB ready, never waits.
	output logic pslverr_o, // APB error on unmapped address.
	input wire logic d_i, // Raw data line from the peer.
	input wire logic s_i, // Raw strobe line from the peer.
	input wire lx_link_pkg::rx_char_t rx_char_i, // Decoded character.
	input wire logic host_room8_i, // Pulse: host has room for 8 more.
	input wire logic tx_char_sent_i, // Pulse: one normal char sent.
	input wire logic tx_invalid_i, // Pulse: host gave invalid char.
	input wire logic tx_fct_done_i, // Pulse: one token was sent.
	output logic tx_on_o, // Transmitter running.
	output logic tx_fct_req_o, // Request to send one token.
	output logic tx_nchar_ok_o, // Normal characters may be sent.
	output logic host_tx_ready_o, // Host may hand over data.
	output logic link_error_o, // Pulse: link error in run.
	output logic tx_error_o, // Pulse: invalid character reported.
	output lx_link_pkg::link_state_t state_o // Current state.
);

	// Cycle counts derived from the printed times.
	localparam int RST_CYC = (`LX_RESET_NS + `LX_CLK_NS - 1) / `LX_CLK_NS;
	localparam int QUI_CYC = (`LX_QUIET_NS + `LX_CLK_NS - 1) / `LX_CLK_NS;
	localparam int TO_CYC = (`LX_TOUT_NS + `LX_CLK_NS - 1) / `LX_CLK_NS;
	localparam int DSC_CYC = (`LX_DISC_NS + `LX_CLK_NS - 1) / `LX_CLK_NS;
	localparam logic [7:0] RST_LAST = 8'(RST_CYC - 1);
	localparam logic [7:0] QUI_LAST = 8'(QUI_CYC - 1);
	localparam logic [7:0] TO_LAST = 8'(TO_CYC - 1);
	localparam logic [3:0] DSC_LAST = 4'(DSC_CYC - 1);
	localparam logic [6:0] STEP = 7'(`LX_CREDIT_STEP);
	localparam logic [6:0] TX_MAX = 7'(TX_CREDIT_MAX);
	localparam logic [6:0] RX_MAX = 7'(RX_CREDIT_MAX);
	// Refuse settings the counters cannot hold, while elaborating.
	if (TX_CREDIT_MAX < `LX_CREDIT_STEP || TX_CREDIT_MAX > 127 ||
		RX_CREDIT_MAX < `LX_CREDIT_STEP || RX_CREDIT_MAX > 127 ||
		RST_CYC > 256 || TO_CYC > 256 || QUI_CYC > 256 ||
		DSC_CYC > 16) begin
		$error("lx_link_exchange: unsupported parameter values");
	end
	// Decodes an APB address into a register number, 3 when unmapped.
	function automatic logic [1:0] reg_index(input logic [7:0] addr);
		if (addr == `LX_CTRL_OFS) begin
			return 2'h0;
		end else if (addr == `LX_STATUS_OFS) begin
			return 2'h1;
		end else if (addr == `LX_ERRCNT_OFS) begin
			return 2'h2;
		end
		return 2'h3;
	endfunction
	lx_link_pkg::lx_state_t st_reg; // Registered state.
	lx_link_pkg::lx_state_t st_next; // Next state.
	logic rx_en; // Receiver enabled outside reset state.
	logic got_null; // Escape followed by token this cycle.
	logic got_fct; // Valid token this cycle.
	logic got_nchar; // Valid normal character this cycle.
	logic is_mark; // Character is an end marker.
	logic par_err; // Parity error after first idle.
	logic esc_err; // Escape error after first idle.
	logic disc_err; // Disconnect detected.
	logic seq_err; // Character out of sequence.
	logic cred_err; // Credit overrun either way.
	logic empty_err; // Empty packet.
	logic fail; // Errors reported as link error in run.
	logic enabled; // Link enabled condition.
	logic line_edge; // Edge on data or strobe.
	logic apb_wr; // APB write in access phase.

	// Error and character decode from the current state.
	always_comb begin
		rx_en = st_reg.state != lx_link_pkg::RESET_HOLD;
		line_edge = (st_reg.d_sync ^ st_reg.d_last) |
			(st_reg.s_sync ^ st_reg.s_last);
		got_null = rx_char_i.valid & rx_en & st_reg.esc_seen &
			!rx_char_i.parity_err & rx_char_i.kind == lx_link_pkg::CK_FCT;
		is_mark = rx_char_i.kind == lx_link_pkg::CK_EOP ||
			rx_char_i.kind == lx_link_pkg::CK_EEP;
		par_err = rx_char_i.valid & rx_en & st_reg.null_seen &
			rx_char_i.parity_err;
		esc_err = rx_char_i.valid & rx_en & st_reg.null_seen &
			st_reg.esc_seen & !rx_char_i.parity_err &
			rx_char_i.kind != lx_link_pkg::CK_FCT;
		got_fct = rx_char_i.valid & rx_en & st_reg.null_seen &
			!st_reg.esc_seen & !rx_char_i.parity_err &
			rx_char_i.kind == lx_link_pkg::CK_FCT;
		got_nchar = rx_char_i.valid & rx_en & st_reg.null_seen &
			!st_reg.esc_seen & !rx_char_i.parity_err &
			rx_char_i.kind != lx_link_pkg::CK_FCT &&
			rx_char_i.kind != lx_link_pkg::CK_ESC;
		// Unexpected tokens or characters while initialising.
		seq_err = (got_fct && (st_reg.state == lx_link_pkg::QUIET_WAIT ||
			st_reg.state == lx_link_pkg::READY ||
			st_reg.state == lx_link_pkg::NULL_SEND)) ||
			(got_nchar && st_reg.state != lx_link_pkg::RUN);
		// No granted credit left, or a token that overfills credit.
		cred_err = (got_nchar && st_reg.state == lx_link_pkg::RUN &&
			st_reg.rx_credit == 7'h00) ||
			(got_fct && st_reg.tx_credit > TX_MAX - STEP);
		empty_err = got_nchar && st_reg.state == lx_link_pkg::RUN &&
			is_mark && st_reg.eop_seen;
		// Silence for longer than the disconnect time once armed.
		disc_err = rx_en && st_reg.disc_armed && !line_edge &&
			st_reg.disc_cnt == DSC_LAST;
		fail = disc_err | par_err | esc_err | cred_err | empty_err;
		enabled = !st_reg.link_off & (st_reg.connect_req |
			(st_reg.auto_conn & st_reg.null_seen));
		apb_wr = psel_i & penable_i & pwrite_i;
	end

	// Next-state logic for the whole controller.
	always_comb begin
		st_next = st_reg;
		st_next.link_err = 1'b0;
		st_next.tx_err = 1'b0;
		// Line pins pass two flip-flops before any use.
		st_next.d_meta = d_i;
		st_next.d_sync = st_reg.d_meta;
		st_next.d_last = st_reg.d_sync;
		st_next.s_meta = s_i;
		st_next.s_sync = st_reg.s_meta;
		st_next.s_last = st_reg.s_sync;
		st_next.timer = st_reg.timer + 8'h01;
		// Disconnect timer restarts on every edge.
		if (line_edge) begin
			st_next.disc_armed = rx_en;
			st_next.disc_cnt = 4'h0;
		end else if (st_reg.disc_armed) begin
			st_next.disc_cnt = st_reg.disc_cnt + 4'h1;
		end
		// Character tracking: escape and end marker memory.
		if (rx_char_i.valid && rx_en) begin
			st_next.esc_seen = !rx_char_i.parity_err &&
				rx_char_i.kind == lx_link_pkg::CK_ESC;
		end
		if (got_null) begin
			st_next.null_seen = 1'b1;
		end
		if (got_nchar) begin
			st_next.eop_seen = is_mark;
		end
		// Transmit credit: tokens add, sent characters take one.
		if (got_fct && (st_reg.state == lx_link_pkg::HANDSHAKE ||
			st_reg.state == lx_link_pkg::RUN) && !cred_err) begin
			st_next.tx_credit = st_reg.tx_credit + STEP -
				{6'h00, tx_char_sent_i};
		end else if (tx_char_sent_i && st_reg.tx_credit != 7'h00) begin
			st_next.tx_credit = st_reg.tx_credit - 7'h01;
		end
		// Granted credit: sent tokens add, received characters take one.
		st_next.rx_credit = st_reg.rx_credit +
			(tx_fct_done_i ? STEP : 7'h00) -
			{6'h00, got_nchar && st_reg.state == lx_link_pkg::RUN &&
			st_reg.rx_credit != 7'h00};
		// Tokens owed to the peer, one per host room pulse.
		st_next.fct_owed = st_reg.fct_owed +
			{3'h0, host_room8_i && st_reg.fct_owed != 4'hF} -
			{3'h0, tx_fct_done_i && st_reg.fct_owed != 4'h0};
		if (tx_invalid_i && st_reg.state == lx_link_pkg::RUN) begin
			st_next.tx_halt = 1'b1;
			st_next.tx_err = 1'b1;
		end
		// State sequencing.
		unique case (st_reg.state)
			lx_link_pkg::RESET_HOLD: begin
				if (st_reg.timer == RST_LAST) begin
					st_next.state = lx_link_pkg::QUIET_WAIT;
					st_next.timer = 8'h00;
				end
			end
			lx_link_pkg::QUIET_WAIT: begin
				if (st_reg.timer == QUI_LAST) begin
					st_next.state = lx_link_pkg::READY;
				end
			end
			lx_link_pkg::READY: begin
				if (enabled) begin
					st_next.state = lx_link_pkg::NULL_SEND;
					st_next.timer = 8'h00;
				end
			end
			lx_link_pkg::NULL_SEND: begin
				if (st_reg.null_seen) begin
					st_next.state = lx_link_pkg::HANDSHAKE;
					st_next.timer = 8'h00;
				end else if (st_reg.timer == TO_LAST) begin
					st_next.state = lx_link_pkg::RESET_HOLD;
				end
			end
			lx_link_pkg::HANDSHAKE: begin
				if (got_fct) begin
					st_next.state = lx_link_pkg::RUN;
				end else if (st_reg.timer == TO_LAST) begin
					st_next.state = lx_link_pkg::RESET_HOLD;
				end
			end
			lx_link_pkg::RUN: st_next.link_err = fail;
		endcase
		// Disable after ready, or any error, silences and resets.
		if (rx_en && ((fail | seq_err) || (st_reg.link_off &&
			st_reg.state != lx_link_pkg::QUIET_WAIT &&
			st_reg.state != lx_link_pkg::READY))) begin
			st_next.state = lx_link_pkg::RESET_HOLD;
		end
		// Entering the reset state drops all link knowledge.
		if (st_next.state == lx_link_pkg::RESET_HOLD &&
			st_reg.state != lx_link_pkg::RESET_HOLD) begin
			st_next.timer = 8'h00;
		end
		if (st_reg.state == lx_link_pkg::RESET_HOLD) begin
			st_next.null_seen = 1'b0;
			st_next.esc_seen = 1'b0;
			st_next.eop_seen = 1'b0;
			st_next.disc_armed = 1'b0;
			st_next.tx_credit = 7'h00;
			st_next.rx_credit = 7'h00;
			st_next.fct_owed = 4'h0;
			st_next.tx_halt = 1'b0;
		end
		// Link error count, cleared by a write; a coinciding error counts.
		if (apb_wr && reg_index(paddr_i) == 2'h2) begin
			st_next.err_count = {7'h00, st_reg.link_err};
		end else if (st_reg.link_err && st_reg.err_count != 8'hFF) begin
			st_next.err_count = st_reg.err_count + 8'h01;
		end
		// Control register write.
		if (apb_wr && reg_index(paddr_i) == 2'h0) begin
			st_next.link_off = pwdata_i[`LX_CTRL_OFF_BIT];
			st_next.connect_req = pwdata_i[`LX_CTRL_START_BIT];
			st_next.auto_conn = pwdata_i[`LX_CTRL_AUTO_BIT];
		end
		// Read data captured in the setup phase.
		if (psel_i && !penable_i) begin
			st_next.prdata = 32'h0000_0000;
			unique case (reg_index(paddr_i))
				2'h0: begin
					st_next.prdata[`LX_CTRL_OFF_BIT] = st_reg.link_off;
					st_next.prdata[`LX_CTRL_START_BIT] = st_reg.connect_req;
					st_next.prdata[`LX_CTRL_AUTO_BIT] = st_reg.auto_conn;
				end
				2'h1: begin
					st_next.prdata[`LX_ST_STATE_LSB +: 3] = st_reg.state;
					st_next.prdata[`LX_ST_NULL_BIT] = st_reg.null_seen;
					st_next.prdata[`LX_ST_HALT_BIT] = st_reg.tx_halt;
					st_next.prdata[`LX_ST_TXCR_LSB +: 7] = st_reg.tx_credit;
					st_next.prdata[`LX_ST_RXCR_LSB +: 7] = st_reg.rx_credit;
				end
				2'h2: st_next.prdata[7:0] = st_reg.err_count;
				2'h3: st_next.prdata = 32'h0000_0000;
			endcase
		end
	end
	// State register with synchronous reset.
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			st_reg <= '0;
			st_reg.state <= lx_link_pkg::RESET_HOLD;
			{st_reg.auto_conn, st_reg.connect_req, st_reg.link_off} <=
				`LX_CTRL_RESET;
		end else begin
			st_reg <= st_next;
		end
	end
	// Outputs toward the bus, transmitter and host.
	always_comb begin
		prdata_o = st_reg.prdata;
		pready_o = 1'b1;
		pslverr_o = psel_i & penable_i & (reg_index(paddr_i) == 2'h3);
		tx_on_o = st_reg.state == lx_link_pkg::NULL_SEND ||
			st_reg.state == lx_link_pkg::HANDSHAKE ||
			st_reg.state == lx_link_pkg::RUN;
		tx_fct_req_o = st_reg.fct_owed != 4'h0 && st_reg.null_seen &&
			st_reg.rx_credit <= RX_MAX - STEP &&
			(st_reg.state == lx_link_pkg::HANDSHAKE ||
			st_reg.state == lx_link_pkg::RUN);
		tx_nchar_ok_o = st_reg.state == lx_link_pkg::RUN &&
			!st_reg.tx_halt;
		host_tx_ready_o = tx_nchar_ok_o &&
			st_reg.tx_credit != 7'h00;
		link_error_o = st_reg.link_err;
		tx_error_o = st_reg.tx_err;
		state_o = st_reg.state;
	end

	a_reset_hold_time: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) (st_reg.state == lx_link_pkg::RESET_HOLD ##1
		st_reg.state == lx_link_pkg::QUIET_WAIT) |->
		$past(st_reg.timer) == RST_LAST)
		else $error("Reset state left at the wrong time.");
	a_quiet_time: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) (st_reg.state == lx_link_pkg::QUIET_WAIT ##1
		st_reg.state == lx_link_pkg::READY) |->
		$past(st_reg.timer) == QUI_LAST)
		else $error("Quiet state left at the wrong time.");
	a_start_enabled: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) (st_reg.state == lx_link_pkg::READY &&
		enabled && !fail && !seq_err && !st_reg.link_off) |=>
		st_reg.state == lx_link_pkg::NULL_SEND)
		else $error("Enabled link did not start sending idles.");
	a_null_handshake: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) (st_reg.state == lx_link_pkg::NULL_SEND &&
		st_reg.null_seen && !fail && !seq_err && !st_reg.link_off) |=>
		st_reg.state == lx_link_pkg::HANDSHAKE)
		else $error("Seen idle did not start the handshake.");
	a_fct_after_null: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) tx_fct_req_o |-> st_reg.null_seen)
		else $error("Token requested before an idle was seen.");
	a_credit_add: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) (got_fct && !tx_char_sent_i && !cred_err &&
		st_reg.state == lx_link_pkg::RUN && !fail && !st_reg.link_off) |=>
		st_reg.tx_credit == $past(st_reg.tx_credit) + STEP)
		else $error("Received token did not add eight credits.");
	a_ready_credit: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) host_tx_ready_o |->
		st_reg.tx_credit != 7'h00)
		else $error("Host offered data with no credit.");
	a_error_in_run: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) link_error_o |->
		$past(st_reg.state) == lx_link_pkg::RUN &&
		st_reg.state == lx_link_pkg::RESET_HOLD)
		else $error("Link error reported outside run.");
	a_silent_reset: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) (st_reg.state != lx_link_pkg::RESET_HOLD &&
		fail) |=> !tx_on_o [*2])
		else $error("Transmitter kept running after an error.");
endmodule

// [design/lx_link_regs.svh]
// Purpose: Offsets, field positions, reset values and times of the link.
// Assumes: A 32-bit APB word per register; times given in nanoseconds.
// Notes: Cycle counts are derived inside the module from these times.
`ifndef LX_LINK_REGS_SVH
`define LX_LINK_REGS_SVH

// Register byte offsets.
`define LX_CTRL_OFS 8'h00
`define LX_STATUS_OFS 8'h04
`define LX_ERRCNT_OFS 8'h08

// Control register field positions and reset values.
`define LX_CTRL_OFF_BIT 0
`define LX_CTRL_START_BIT 1
`define LX_CTRL_AUTO_BIT 2
`define LX_CTRL_RESET 3'h0

// Status register field positions.
`define LX_ST_STATE_LSB 0
`define LX_ST_NULL_BIT 4
`define LX_ST_HALT_BIT 5
`define LX_ST_TXCR_LSB 8
`define LX_ST_RXCR_LSB 16

// Timing in nanoseconds and the system clock period.
`define LX_CLK_NS 100
`define LX_RESET_NS 6400
`define LX_QUIET_NS 12800
`define LX_TOUT_NS 12800
`define LX_DISC_NS 850

// Credit carried by one flow credit token, in normal characters.
`define LX_CREDIT_STEP 8

`endif

// [design/lx_link_pkg.sv]
// Purpose: Types shared by the link exchange controller and its bench.
// Assumes: Constants live in lx_link_regs.svh.
// Notes: Nothing here is imported; users write lx_link_pkg::name.
package lx_link_pkg;

	// Exchange states in the order the link walks them.
	typedef enum logic [2:0] {
		RESET_HOLD,
		QUIET_WAIT,
		READY,
		NULL_SEND,
		HANDSHAKE,
		RUN
	} link_state_t;

	// Kind of character delivered by the character decoder.
	typedef enum logic [2:0] {
		CK_FCT,
		CK_ESC,
		CK_EOP,
		CK_EEP,
		CK_DATA
	} char_kind_t;

	// One decoded character from the receiver.
	typedef struct packed {
		logic valid;
		char_kind_t kind;
		logic parity_err;
	} rx_char_t;

	// Whole state of the controller.
	typedef struct packed {
		link_state_t state;
		logic [7:0] timer;
		logic [3:0] disc_cnt;
		logic d_meta;
		logic d_sync;
		logic d_last;
		logic s_meta;
		logic s_sync;
		logic s_last;
		logic disc_armed;
		logic null_seen;
		logic esc_seen;
		logic eop_seen;
		logic [6:0] tx_credit;
		logic [6:0] rx_credit;
		logic [3:0] fct_owed;
		logic tx_halt;
		logic link_err;
		logic tx_err;
		logic link_off;
		logic connect_req;
		logic auto_conn;
		logic [7:0] err_count;
		logic [31:0] prdata;
	} lx_state_t;

endpackage

// [tb/lx_peer_model.sv]
// Purpose: Peer link end: line activity, decoded characters, token answers.
// Assumes: The bench calls send and quiet from its own process.
// Notes: The link clock stands still while the peer is silent.
`timescale 1ns/100ps

module lx_peer_model #(
	parameter int DLY = 3 // Cycles before a requested token goes out.
) (
	input wire logic clk_sys_i, // System clock.
	input wire logic line_on_i, // Peer transmitter running.
	input wire logic fct_req_i, // Our end asks for one token.
	output logic d_o, // Data line.
	output logic s_o, // Strobe line.
	output lx_link_pkg::rx_char_t char_o, // Decoded character.
	output logic fct_done_o // Pulse: one token sent.
);
	logic lclk = 1'b0; // Link clock, 800 ns period.
	int wait_n = 0; // Cycles waited on a token request.

	// Link clock runs only while the peer transmits.
	initial begin
		d_o = 1'b0;
		s_o = 1'b0;
		char_o = '0;
		fct_done_o = 1'b0;
		#37;
		forever #400 lclk = line_on_i ? ~lclk : lclk;
	end

	// Each bit moves exactly one of data and strobe.
	always @(lclk) begin
		if (lclk) d_o = ~d_o;
		else s_o = ~s_o;
	end

	// One token goes out per request, a few cycles late.
	always @(posedge clk_sys_i) begin
		fct_done_o <= 1'b0;
		if (fct_req_i && !fct_done_o) begin
			wait_n <= (wait_n == DLY) ? 0 : wait_n + 1;
			if (wait_n == DLY) fct_done_o <= 1'b1;
		end else begin
			wait_n <= 0;
		end
	end

	// Presents one character for one clock.
	task automatic send(input lx_link_pkg::char_kind_t k, input logic pe);
		@(posedge clk_sys_i);
		char_o <= '{valid: 1'b1, kind: k, parity_err: pe};
	endtask

	// Ends a run of characters.
	task automatic quiet();
		@(posedge clk_sys_i);
		char_o <= '0;
	endtask
endmodule

// [tb/link_exchange_state_machine_tb_top.sv]
// Purpose: Self-checking bench of the link exchange controller.
// Assumes: APB answers in the access cycle; peer model on the far side.
// Notes: Each scenario starts from a fresh reset.
`timescale 1ns/100ps
`include "lx_link_regs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
	n_mismatch++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end

module link_exchange_state_machine_tb_top;
	logic clk_sys_i = 1'b0, reset_i = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, d, s, room8 = 1'b0, sent = 1'b0;
	logic inval = 1'b0, fdone, tx_on, freq, nok, hrdy, lerr, terr;
	logic line_on = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	lx_link_pkg::rx_char_t rxc;
	lx_link_pkg::link_state_t state;
	int n_mismatch = 0, tests_run = 0, lerr_cnt = 0, terr_cnt = 0;
	logic er;

	lx_link_exchange dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .d_i(d), .s_i(s),
		.rx_char_i(rxc), .host_room8_i(room8), .tx_char_sent_i(sent),
		.tx_invalid_i(inval), .tx_fct_done_i(fdone), .tx_on_o(tx_on),
		.tx_fct_req_o(freq), .tx_nchar_ok_o(nok), .host_tx_ready_o(hrdy),
		.link_error_o(lerr), .tx_error_o(terr), .state_o(state));
	lx_peer_model peer (.clk_sys_i(clk_sys_i), .line_on_i(line_on),
		.fct_req_i(freq), .d_o(d), .s_o(s), .char_o(rxc),
		.fct_done_o(fdone));

	// Clock of 100 ns period.
	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	// Counts the one-cycle error pulses.
	always @(posedge clk_sys_i) begin
		if (lerr === 1'b1) lerr_cnt++;
		if (terr === 1'b1) terr_cnt++;
	end

	// Prints the counts and the verdict, then stops.
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// Waits whole cycles, then settles past the edge.
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	// One APB transfer held until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge clk_sys_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys_i);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Waits a bounded time for a state, then compares it.
	task automatic wait_state(input lx_link_pkg::link_state_t st,
		input int lim);
		int n;
		n = 0;
		while (state !== st && n < lim) begin
			tick(1);
			n++;
		end
		`CHK("state", st, state)
	endtask

	// Synchronous reset for 20 cycles.
	task automatic do_reset();
		@(posedge clk_sys_i);
		reset_i <= 1'b1;
		repeat (20) @(posedge clk_sys_i);
		reset_i <= 1'b0;
	endtask

	// An idle character from the peer.
	task automatic null_in();
		peer.send(lx_link_pkg::CK_ESC, 1'b0);
		peer.send(lx_link_pkg::CK_FCT, 1'b0);
		peer.quiet();
	endtask

	// Brings the link to run with one token exchanged each way.
	task automatic bring_up();
		do_reset();
		line_on <= 1'b1;
		wait_state(lx_link_pkg::READY, 300);
		apb(1'b1, `LX_CTRL_OFS, 32'h2);
		wait_state(lx_link_pkg::NULL_SEND, 5);
		@(posedge clk_sys_i);
		room8 <= 1'b1;
		@(posedge clk_sys_i);
		room8 <= 1'b0;
		tick(3);
		`CHK("token before idle", 1'b0, freq)
		null_in();
		wait_state(lx_link_pkg::HANDSHAKE, 5);
		tick(8);
		peer.send(lx_link_pkg::CK_FCT, 1'b0);
		peer.quiet();
		wait_state(lx_link_pkg::RUN, 5);
	endtask

	// Reset and quiet timing, then the registers.
	task automatic s_timing();
		do_reset();
		line_on <= 1'b0;
		tick(63);
		`CHK("hold", lx_link_pkg::RESET_HOLD, state)
		`CHK("silent", 1'b0, tx_on)
		tick(4);
		`CHK("quiet", lx_link_pkg::QUIET_WAIT, state)
		tick(122);
		`CHK("quiet", lx_link_pkg::QUIET_WAIT, state)
		`CHK("silent", 1'b0, tx_on)
		tick(8);
		`CHK("ready", lx_link_pkg::READY, state)
		apb(1'b0, `LX_CTRL_OFS, 32'h0);
		`CHK("ctrl", 32'h0, rd)
		apb(1'b0, `LX_STATUS_OFS, 32'h0);
		`CHK("status", 32'h2, rd)
		apb(1'b0, 8'h0C, 32'h0);
		`CHK("unmapped", 1'b1, er)
		apb(1'b1, `LX_CTRL_OFS, 32'h2);
		wait_state(lx_link_pkg::NULL_SEND, 5);
		tick(124);
		`CHK("waiting", lx_link_pkg::NULL_SEND, state)
		tick(8);
		`CHK("timeout", lx_link_pkg::RESET_HOLD, state)
		`CHK("silent", 1'b0, tx_on)
	endtask

	// Credit on both sides, then an invalid transmit character.
	task automatic s_run();
		bring_up();
		apb(1'b0, `LX_STATUS_OFS, 32'h0);
		`CHK("tx credit", 7'h08, rd[14:8])
		`CHK("rx credit", 7'h08, rd[22:16])
		`CHK("host ready", 1'b1, hrdy)
		@(posedge clk_sys_i);
		sent <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		sent <= 1'b0;
		tick(2);
		`CHK("host ready", 1'b0, hrdy)
		peer.send(lx_link_pkg::CK_FCT, 1'b0);
		peer.quiet();
		tick(1);
		`CHK("credit back", 1'b1, hrdy)
		@(posedge clk_sys_i);
		inval <= 1'b1;
		@(posedge clk_sys_i);
		inval <= 1'b0;
		tick(3);
		`CHK("tx error", 1, terr_cnt)
		`CHK("nchar ok", 1'b0, nok)
		`CHK("still run", lx_link_pkg::RUN, state)
	endtask

	// Receiver errors in run: parity, escape, credit, empty, disconnect.
	task automatic s_errors();
		int c0;
		for (int k = 0; k < 5; k++) begin
			bring_up();
			c0 = lerr_cnt;
			case (k)
				0: peer.send(lx_link_pkg::CK_EOP, 1'b1);
				1: begin
					peer.send(lx_link_pkg::CK_ESC, 1'b0);
					peer.send(lx_link_pkg::CK_EOP, 1'b0);
				end
				2: repeat (9) peer.send(lx_link_pkg::CK_DATA, 1'b0);
				3: begin
					peer.send(lx_link_pkg::CK_EOP, 1'b0);
					peer.send(lx_link_pkg::CK_EEP, 1'b0);
				end
				default: begin
					@(posedge clk_sys_i);
					line_on <= 1'b0;
				end
			endcase
			peer.quiet();
			wait_state(lx_link_pkg::RESET_HOLD, 30);
			tick(2);
			`CHK("silenced", 1'b0, tx_on)
			`CHK("link error", 1, lerr_cnt - c0)
			apb(1'b0, `LX_ERRCNT_OFS, 32'h0);
			`CHK("error count", 8'h01, rd[7:0])
		end
	endtask

	// Disable, sequence error and autostart, none reported.
	task automatic s_sequence();
		int c0;
		bring_up();
		c0 = lerr_cnt;
		apb(1'b1, `LX_CTRL_OFS, 32'h1);
		wait_state(lx_link_pkg::RESET_HOLD, 5);
		apb(1'b1, `LX_CTRL_OFS, 32'h0);
		wait_state(lx_link_pkg::READY, 300);
		null_in();
		tick(20);
		`CHK("ready kept", lx_link_pkg::READY, state)
		peer.send(lx_link_pkg::CK_DATA, 1'b0);
		peer.quiet();
		wait_state(lx_link_pkg::RESET_HOLD, 5);
		wait_state(lx_link_pkg::READY, 300);
		apb(1'b1, `LX_CTRL_OFS, 32'h4);
		tick(5);
		`CHK("auto waits", lx_link_pkg::READY, state)
		null_in();
		wait_state(lx_link_pkg::NULL_SEND, 5);
		wait_state(lx_link_pkg::HANDSHAKE, 5);
		tick(120);
		`CHK("no token yet", lx_link_pkg::HANDSHAKE, state)
		tick(10);
		`CHK("token timeout", lx_link_pkg::RESET_HOLD, state)
		`CHK("unreported", 0, lerr_cnt - c0)
	endtask

	// Watchdog cuts a hang short.
	initial begin
		#3000000;
		n_mismatch++;
		wrap_up();
	end

	// Main sequence.
	initial begin
		s_timing();
		s_run();
		s_errors();
		s_sequence();
		wrap_up();
	end
endmodule
